// File: hw/adc_serial_register_port.sv
`timescale 1ns/1ns
// Function
// - mode 3: launch falling, capture rising
// - four-wire with select, or select tied low
// - first byte of each transaction is command
// - command: write-enable, read/write, register select
// - after data phase, wait for next command
// - data phase 8, 16 or 24 bits
// - read-only part code register for link check
// - 64 ones on input reset whole device
// - select high aborts transfer, interface idles
// - reset: channel 0 on, inputs 0/1, setup 0
// - reset setup: internal ref, input buffers on
// - reset filter: sinc5 plus sinc1, full rate
// - reset mode: continuous, internal oscillator
// - reset: checksum off, no status appended
// - four channels, four setups, any pairing
// - channel: enable, setup, positive, negative inputs
// - sequencer steps ascending through enabled, wraps
// - disabled channels are skipped
module adc_serial_register_port
   import adc_port_pkg::*;
#(
   parameter logic [15:0] PART_CODE    = 16'h1230, // arbitrary value
   parameter logic [23:0] GAIN_RST     = 24'h500000,
   parameter int          HIGH_RUN     = adc_port_pkg::HIGH_RUN_LEN
) (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // serial link pins
   input  wire logic       sclk_i,
   input  wire logic       cs_n_i,
   input  wire logic       din_i,
   output logic            dout_o,
   output logic            dout_oe_n_o,
   // sequencer state
   output logic      [1:0] active_chan_o
);
   import adc_port_pkg::*;

   // the ones counter is seven bits wide
   if (HIGH_RUN < 2 || HIGH_RUN > 127) begin : g_run_check
      $error("HIGH_RUN must lie in 2..127");
   end

   logic        sclk_f;
   logic        cs_n_f;
   logic        din_f;
   logic        sclk_d_q;
   logic        rise_w;
   logic        fall_w;
   logic [6:0]  hi_cnt_q;
   logic        dev_rst_q;
   port_state_t st_q;
   logic [4:0]  bit_q;
   logic [4:0]  len_q;
   logic [5:0]  addr_q;
   logic [23:0] sh_q;
   logic        wr_stb_q;
   logic [23:0] wr_data_q;
   logic [7:0]  cmd_w;
   logic [23:0] rd_word;
   logic [15:0] adcmode_q;
   logic [15:0] ifmode_q;
   logic [15:0] ch_q    [4];
   logic [15:0] setup_q [4];
   logic [15:0] filt_q  [4];
   logic [23:0] offs_q  [4];
   logic [23:0] gain_q  [4];
   logic [3:0]  ch_en_w;
   logic [10:0] conv_cnt_q;
   logic        tick_q;

   // sclk idles high and select idles high at reset
   pin_sync #(
      .WIDTH   (3),
      .RST_VAL (3'b110)
   ) u_pin_sync (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pins_i     ({sclk_i, cs_n_i, din_i}),
      .pins_o     ({sclk_f, cs_n_f, din_f})
   );

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_d_q <= 1'b1;
      end else begin
         sclk_d_q <= sclk_f;
      end
   end

   assign rise_w = sclk_f & ~sclk_d_q;
   assign fall_w = ~sclk_f & sclk_d_q;

   // run of ones; this also recovers a host that lost byte framing
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_cnt_q  <= 7'h00;
         dev_rst_q <= 1'b0;
      end else begin
         dev_rst_q <= 1'b0;
         if (dev_rst_q) begin
            hi_cnt_q <= 7'h00;
         end else if (rise_w) begin
            if (!din_f) begin
               hi_cnt_q <= 7'h00;
            end else if (hi_cnt_q == 7'(HIGH_RUN - 1)) begin
               hi_cnt_q  <= 7'h00;
               dev_rst_q <= 1'b1;
            end else begin
               hi_cnt_q <= hi_cnt_q + 7'h01;
            end
         end
      end
   end

   assign cmd_w = {sh_q[6:0], din_f};

   // transaction engine, runs on synchronised link edges
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q      <= ST_CMD;
         bit_q     <= 5'h00;
         len_q     <= LEN_8;
         addr_q    <= ADDR_COMMAND;
         sh_q      <= 24'h000000;
         wr_stb_q  <= 1'b0;
         wr_data_q <= 24'h000000;
      end else if (dev_rst_q || cs_n_f) begin
         st_q     <= ST_CMD;
         bit_q    <= 5'h00;
         wr_stb_q <= 1'b0;
      end else begin
         wr_stb_q <= 1'b0;
         if (rise_w) begin
            case (st_q)
               ST_CMD: begin
                  sh_q <= {sh_q[22:0], din_f};
                  if (bit_q == CMD_LAST_BIT) begin
                     bit_q <= 5'h00;
                     // a set write-enable flag voids the byte
                     if (!cmd_w[CMD_WEN_BIT]) begin
                        addr_q <= cmd_w[5:0];
                        len_q  <= reg_len(cmd_w[5:0]);
                        if (cmd_w[CMD_RD_BIT]) begin
                           st_q <= ST_RD;
                           sh_q <= rd_word << (LEN_24 -
                                               reg_len(cmd_w[5:0]));
                        end else begin
                           st_q <= ST_WR;
                        end
                     end
                  end else begin
                     bit_q <= bit_q + 5'h01;
                  end
               end
               ST_WR: begin
                  sh_q <= {sh_q[22:0], din_f};
                  if (bit_q == len_q - 5'h01) begin
                     wr_stb_q  <= 1'b1;
                     wr_data_q <= {sh_q[22:0], din_f};
                     st_q      <= ST_CMD;
                     bit_q     <= 5'h00;
                  end else begin
                     bit_q <= bit_q + 5'h01;
                  end
               end
               ST_RD: begin
                  if (bit_q == len_q - 5'h01) begin
                     st_q  <= ST_CMD;
                     bit_q <= 5'h00;
                  end else begin
                     bit_q <= bit_q + 5'h01;
                  end
               end
               default: begin
                  st_q  <= ST_CMD;
                  bit_q <= 5'h00;
               end
            endcase
         end else if (fall_w && st_q == ST_RD) begin
            sh_q <= {sh_q[22:0], 1'b0};
         end
      end
   end

   // output launched on falling edges; enable follows select
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dout_o      <= 1'b1;
         dout_oe_n_o <= 1'b1;
      end else begin
         dout_oe_n_o <= cs_n_f;
         if (fall_w) begin
            dout_o <= (st_q == ST_RD) ? sh_q[23] : 1'b1;
         end
      end
   end

   // read mux; unmapped addresses answer eight zero bits
   always_comb begin
      rd_word = 24'h000000;
      if (cmd_w[5:0] == ADDR_ADCMODE) begin
         rd_word = {8'h00, adcmode_q};
      end else if (cmd_w[5:0] == ADDR_IFMODE) begin
         rd_word = {8'h00, ifmode_q};
      end else if (cmd_w[5:0] == ADDR_PART_CODE) begin
         rd_word = {8'h00, PART_CODE};
      end else begin
         case (cmd_w[5:2])
            ADDR_CH_BASE[5:2]:    rd_word = {8'h00, ch_q[cmd_w[1:0]]};
            ADDR_SETUP_BASE[5:2]: rd_word = {8'h00, setup_q[cmd_w[1:0]]};
            ADDR_FILT_BASE[5:2]:  rd_word = {8'h00, filt_q[cmd_w[1:0]]};
            ADDR_OFFS_BASE[5:2]:  rd_word = offs_q[cmd_w[1:0]];
            ADDR_GAIN_BASE[5:2]:  rd_word = gain_q[cmd_w[1:0]];
            default:              rd_word = 24'h000000;
         endcase
      end
   end

   // register store; the part code is never written
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         adcmode_q <= ADCMODE_RST;
         ifmode_q  <= IFMODE_RST;
         for (int i = 0; i < 4; i++) begin
            ch_q[i]    <= (i == 0) ? CH0_RST : CHN_RST;
            setup_q[i] <= SETUP_RST;
            filt_q[i]  <= FILT_RST;
            offs_q[i]  <= OFFS_RST;
            gain_q[i]  <= GAIN_RST;
         end
      end else if (dev_rst_q) begin
         adcmode_q <= ADCMODE_RST;
         ifmode_q  <= IFMODE_RST;
         for (int i = 0; i < 4; i++) begin
            ch_q[i]    <= (i == 0) ? CH0_RST : CHN_RST;
            setup_q[i] <= SETUP_RST;
            filt_q[i]  <= FILT_RST;
            offs_q[i]  <= OFFS_RST;
            gain_q[i]  <= GAIN_RST;
         end
      end else if (wr_stb_q) begin
         if (addr_q == ADDR_ADCMODE) begin
            adcmode_q <= wr_data_q[15:0];
         end else if (addr_q == ADDR_IFMODE) begin
            ifmode_q <= wr_data_q[15:0];
         end else begin
            case (addr_q[5:2])
               ADDR_CH_BASE[5:2]:    ch_q[addr_q[1:0]]    <= wr_data_q[15:0];
               ADDR_SETUP_BASE[5:2]: setup_q[addr_q[1:0]] <= wr_data_q[15:0];
               ADDR_FILT_BASE[5:2]:  filt_q[addr_q[1:0]]  <= wr_data_q[15:0];
               ADDR_OFFS_BASE[5:2]:  offs_q[addr_q[1:0]]  <= wr_data_q;
               ADDR_GAIN_BASE[5:2]:  gain_q[addr_q[1:0]]  <= wr_data_q;
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         ch_en_w[i] = ch_q[i][CH_EN_BIT];
      end
   end

   // conversion pacing at full rate; only continuous mode steps
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         conv_cnt_q <= 11'h000;
         tick_q     <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (dev_rst_q ||
             adcmode_q[ADCMODE_MODE_LSB +: 3] != MODE_CONT) begin
            conv_cnt_q <= 11'h000;
         end else if (conv_cnt_q == 11'(CONV_CYCLES - 1)) begin
            conv_cnt_q <= 11'h000;
            tick_q     <= 1'b1;
         end else begin
            conv_cnt_q <= conv_cnt_q + 11'h001;
         end
      end
   end

   chan_sequencer u_chan_sequencer (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .clear_i    (dev_rst_q),
      .step_i     (tick_q),
      .enable_i   (ch_en_w),
      .chan_o     (active_chan_o)
   );

   a_dout_on_fall: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      dout_o != $past(dout_o) |-> $past(fall_w, 1))
      else $error("data output moved without a falling edge");

   a_cs_abort: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      cs_n_f |=> st_q == ST_CMD && bit_q == 5'h00)
      else $error("select high did not idle the interface");

   a_cmd_first: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == ST_CMD && rise_w && bit_q != CMD_LAST_BIT
      |=> st_q == ST_CMD)
      else $error("left command phase before eight bits");

   a_wen_reject: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      st_q == ST_CMD && rise_w && bit_q == CMD_LAST_BIT && sh_q[6]
      && !cs_n_f && !dev_rst_q |=> st_q == ST_CMD)
      else $error("command with write-enable set was accepted");

   a_phase_return: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      st_q != ST_CMD && rise_w && bit_q == len_q - 5'h01
      |=> st_q == ST_CMD ##1 st_q == ST_CMD)
      else $error("no return to command phase after data");

   a_len_legal: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      st_q != ST_CMD |-> len_q == LEN_8 || len_q == LEN_16 ||
      len_q == LEN_24)
      else $error("illegal data phase length");

   a_full_reset: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rise_w && din_f && hi_cnt_q == 7'(HIGH_RUN - 1) && !dev_rst_q
      |=> dev_rst_q ##1 ch_q[0] == CH0_RST && adcmode_q == ADCMODE_RST
      && st_q == ST_CMD)
      else $error("run of ones did not reset the device");

   a_high_clear: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      rise_w && !din_f |=> hi_cnt_q == 7'h00)
      else $error("low bit did not clear the ones count");
endmodule

// File: hw/adc_port_pkg.sv
package adc_port_pkg;

   // register addresses (six-bit register_select field)
   localparam logic [5:0] ADDR_COMMAND   = 6'h00;
   localparam logic [5:0] ADDR_ADCMODE   = 6'h01;
   localparam logic [5:0] ADDR_IFMODE    = 6'h02;
   localparam logic [5:0] ADDR_PART_CODE = 6'h07;
   localparam logic [5:0] ADDR_CH_BASE   = 6'h10;
   localparam logic [5:0] ADDR_SETUP_BASE = 6'h20;
   localparam logic [5:0] ADDR_FILT_BASE = 6'h28;
   localparam logic [5:0] ADDR_OFFS_BASE = 6'h30;
   localparam logic [5:0] ADDR_GAIN_BASE = 6'h38;

   // command byte fields
   localparam int CMD_WEN_BIT = 7;
   localparam int CMD_RD_BIT  = 6;
   localparam logic [4:0] CMD_LAST_BIT = 5'h07;

   // channel and mode register fields
   localparam int CH_EN_BIT        = 15;
   localparam int CH_SETUP_LSB     = 12;
   localparam int ADCMODE_MODE_LSB = 4;
   localparam logic [2:0] MODE_CONT = 3'h0;

   // values after reset
   localparam logic [7:0]  COMMAND_RST = 8'h00;
   localparam logic [15:0] ADCMODE_RST = 16'h8000;
   localparam logic [15:0] IFMODE_RST  = 16'h0000;
   localparam logic [15:0] CH0_RST     = 16'h8001;
   localparam logic [15:0] CHN_RST     = 16'h0001;
   localparam logic [15:0] SETUP_RST   = 16'h1320;
   localparam logic [15:0] FILT_RST    = 16'h0507;
   localparam logic [23:0] OFFS_RST    = 24'h800000;

   // data phase lengths in bits
   localparam logic [4:0] LEN_8  = 5'h08;
   localparam logic [4:0] LEN_16 = 5'h10;
   localparam logic [4:0] LEN_24 = 5'h18;

   // counts
   localparam int HIGH_RUN_LEN   = 64;
   localparam int CLK_PERIOD_NS  = 50;
   localparam int CONV_PERIOD_NS = 100000;
   localparam int CONV_CYCLES    = CONV_PERIOD_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_CMD = 2'b00,
      ST_WR  = 2'b01,
      ST_RD  = 2'b11
   } port_state_t;

   function automatic logic [4:0] reg_len(input logic [5:0] addr);
      logic [3:0] grp;
      grp = addr[5:2];
      reg_len = LEN_8;
      if (addr == ADDR_ADCMODE || addr == ADDR_IFMODE ||
          addr == ADDR_PART_CODE)
         reg_len = LEN_16;
      else if (grp == ADDR_CH_BASE[5:2] || grp == ADDR_SETUP_BASE[5:2] ||
               grp == ADDR_FILT_BASE[5:2])
         reg_len = LEN_16;
      else if (grp == ADDR_OFFS_BASE[5:2] || grp == ADDR_GAIN_BASE[5:2])
         reg_len = LEN_24;
   endfunction

endpackage

// File: hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
   parameter int               WIDTH   = 3,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // pins and filtered levels
   input  wire logic [WIDTH-1:0] pins_i,
   output logic      [WIDTH-1:0] pins_o
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   if (WIDTH < 1) begin : g_width_check
      $error("WIDTH must be at least 1");
   end

   // a level counts only once the second and third stage agree
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q   <= RST_VAL;
         s2_q   <= RST_VAL;
         s3_q   <= RST_VAL;
         pins_o <= RST_VAL;
      end else begin
         s1_q <= pins_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
               pins_o[i] <= s3_q[i];
            end
         end
      end
   end
endmodule

// File: hw/chan_sequencer.sv
`timescale 1ns/1ns
module chan_sequencer (
   // clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       rst_n_i,
   // control
   input  wire logic       clear_i,
   input  wire logic       step_i,
   input  wire logic [3:0] enable_i,
   // current channel
   output logic      [1:0] chan_o
);
   function automatic logic [1:0] next_chan(input logic [1:0] cur,
                                            input logic [3:0] en);
      logic [1:0] c;
      logic       found;
      found = 1'b0;
      next_chan = cur;
      for (int k = 1; k <= 4; k++) begin
         c = cur + 2'(k);
         if (!found && en[c]) begin
            next_chan = c;
            found = 1'b1;
         end
      end
   endfunction

   // ascending, wrapping, disabled slots skipped
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_o <= 2'h0;
      end else if (clear_i) begin
         chan_o <= 2'h0;
      end else if (step_i) begin
         chan_o <= next_chan(chan_o, enable_i);
      end
   end

   a_seq_skip_off: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      step_i && !clear_i && enable_i != 4'h0
      |=> (($past(enable_i) >> chan_o) & 4'h1) != 4'h0)
      else $error("sequencer landed on a disabled channel");

   a_seq_ascend: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      step_i && !clear_i && ((enable_i >> (chan_o + 2'h1)) & 4'h1) != 4'h0
      |=> chan_o == $past(chan_o) + 2'h1)
      else $error("sequencer did not step to the next channel");
endmodule

// File: dv/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
   // clock
   input  wire logic core_clk_i,
   // link
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      din_o,
   input  wire logic dout_i
);

   initial begin
      sclk_o = 1'b1;
      cs_n_o = 1'b1;
      din_o  = 1'b0;
   end

   // select settles through the pin synchronisers before the first edge
   task automatic link_open;
      @(negedge core_clk_i);
      cs_n_o = 1'b0;
      repeat (6) @(negedge core_clk_i);
   endtask

   // sclk stays high while select is released
   task automatic link_close;
      @(negedge core_clk_i);
      cs_n_o = 1'b1;
      repeat (6) @(negedge core_clk_i);
   endtask

   // 400 ns link clock; the answer lags by the synchronisers, so the
   // read bit is taken late in the high half instead of at the rise
   task automatic shift_bit(input logic b, output logic r);
      @(negedge core_clk_i);
      sclk_o = 1'b0;
      @(negedge core_clk_i);
      din_o = b;
      repeat (3) @(negedge core_clk_i);
      sclk_o = 1'b1;
      repeat (3) @(negedge core_clk_i);
      r = dout_i;
   endtask

   // n bits msb first, both directions
   task automatic xfer(input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
      logic r;
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         shift_bit(tx[i], r);
         rx = {rx[30:0], r};
      end
   endtask

endmodule

// File: dv/adc_serial_register_port_test.sv
`timescale 1ns/1ns
module adc_serial_register_port_test;
   import adc_port_pkg::*;

   localparam logic [15:0] CODE     = 16'h5a3c; // arbitrary value
   localparam logic [23:0] GAIN0    = 24'h512340;
   localparam int          RUN      = 8; // shortened run-of-ones count
   localparam logic [3:0]  SEQ_MASK = 4'b1101;

   logic       core_clk;
   logic       rst_n;
   logic       sclk;
   logic       cs_n;
   logic       din;
   logic       dout;
   logic       dout_oe_n;
   logic [1:0] active_chan;
   logic       last_q;
   logic       sdo;
   int         fails;
   int         checks_done;

   // released line shows the inverse of its last driven level
   assign sdo = (dout_oe_n === 1'b0) ? dout : ~last_q;
   always @(posedge core_clk) begin
      if (dout_oe_n === 1'b0)
         last_q <= dout;
   end

   adc_serial_register_port #(
      .PART_CODE (CODE),
      .GAIN_RST  (GAIN0),
      .HIGH_RUN  (RUN)
   ) i_adc_serial_register_port (
      .core_clk_i    (core_clk),
      .rst_n_i       (rst_n),
      .sclk_i        (sclk),
      .cs_n_i        (cs_n),
      .din_i         (din),
      .dout_o        (dout),
      .dout_oe_n_o   (dout_oe_n),
      .active_chan_o (active_chan)
   );

   spi_host_model i_spi_host_model (
      .core_clk_i (core_clk),
      .sclk_o     (sclk),
      .cs_n_o     (cs_n),
      .din_o      (din),
      .dout_i     (sdo)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic results;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic compare(input logic [23:0] got, input logic [23:0] exp,
                          input string what);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // data phase length by address, worked out independently
   function automatic int blen(input logic [5:0] a);
      if (a inside {6'h01, 6'h02, 6'h07} || a[5:2] inside {4'h4, 4'h8, 4'ha})
         return 16;
      if (a[5:2] inside {4'hc, 4'he})
         return 24;
      return 8;
   endfunction

   task automatic access(input logic rd, input logic [5:0] a,
                         input logic [23:0] wd, output logic [23:0] q);
      logic [31:0] rx;
      i_spi_host_model.xfer({24'h0, 1'b0, rd, a}, 8, rx);
      i_spi_host_model.xfer({8'h0, wd}, blen(a), rx);
      q = rx[23:0];
   endtask

   task automatic rd_check(input logic [5:0] a, input logic [23:0] exp);
      logic [23:0] q;
      access(1'b1, a, 24'h0, q);
      compare(q, exp, "register read");
   endtask

   task automatic ones(input int n);
      logic [31:0] rx;
      for (int i = 0; i < n; i++)
         i_spi_host_model.xfer(32'h1, 1, rx);
   endtask

   task automatic test_defaults;
      i_spi_host_model.link_open();
      rd_check(ADDR_PART_CODE, {8'h0, CODE});
      rd_check(6'h10, 24'h008001);
      rd_check(6'h11, 24'h000001);
      rd_check(6'h20, 24'h001320);
      rd_check(6'h23, 24'h001320);
      rd_check(6'h28, 24'h000507);
      rd_check(6'h01, 24'h008000);
      rd_check(6'h02, 24'h000000);
      rd_check(6'h30, 24'h800000);
      rd_check(6'h38, GAIN0);
      rd_check(6'h05, 24'h000000);
      i_spi_host_model.link_close();
      $display("test_defaults done");
   endtask

   task automatic test_write;
      logic [23:0] q;
      logic [31:0] rx;
      i_spi_host_model.link_open();
      access(1'b0, 6'h11, 24'h00b083, q);
      rd_check(6'h11, 24'h00b083);
      access(1'b0, 6'h33, 24'h123456, q);
      rd_check(6'h33, 24'h123456);
      // no run of ones here: a long one would reset the device
      access(1'b0, ADDR_PART_CODE, 24'h00a5c3, q);
      rd_check(ADDR_PART_CODE, {8'h0, CODE});
      i_spi_host_model.xfer(32'hc7, 8, rx);
      rd_check(ADDR_PART_CODE, {8'h0, CODE});
      i_spi_host_model.link_close();
      $display("test_write done");
   endtask

   task automatic test_abort;
      logic [31:0] rx;
      i_spi_host_model.link_open();
      compare({23'h0, dout_oe_n}, 24'h0, "output enable on");
      i_spi_host_model.xfer(32'h10, 8, rx);
      i_spi_host_model.xfer(32'h00, 8, rx);
      i_spi_host_model.link_close();
      compare({23'h0, dout_oe_n}, 24'h1, "output enable");
      i_spi_host_model.link_open();
      rd_check(6'h10, 24'h008001);
      i_spi_host_model.link_close();
      $display("test_abort done");
   endtask

   task automatic test_run_reset;
      logic [31:0] rx;
      i_spi_host_model.link_open();
      ones(RUN - 1);
      i_spi_host_model.xfer(32'h0, 1, rx);
      ones(RUN - 1);
      i_spi_host_model.link_close();
      i_spi_host_model.link_open();
      rd_check(6'h11, 24'h00b083);
      ones(RUN);
      i_spi_host_model.link_close();
      i_spi_host_model.link_open();
      rd_check(6'h11, 24'h000001);
      rd_check(6'h33, 24'h800000);
      i_spi_host_model.link_close();
      compare({22'h0, active_chan}, 24'h0, "channel after reset");
      $display("test_run_reset done");
   endtask

   function automatic logic [1:0] nxt(input logic [1:0] cur);
      for (int i = 1; i <= 4; i++)
         if (SEQ_MASK[(cur + i) % 4])
            return 2'((cur + i) % 4);
      return cur;
   endfunction

   // a step is 2000 clocks apart; the bound leaves a small margin
   task automatic seq_step;
      logic [1:0] cur;
      int         n;
      cur = active_chan;
      n = 0;
      while (active_chan === cur && n < 2200) begin
         @(negedge core_clk);
         n++;
      end
      compare({22'h0, active_chan}, {22'h0, nxt(cur)}, "channel step");
   endtask

   task automatic test_sequencer;
      logic [23:0] q;
      i_spi_host_model.link_open();
      access(1'b0, 6'h12, 24'h008001, q);
      access(1'b0, 6'h13, 24'h008001, q);
      i_spi_host_model.link_close();
      repeat (4) seq_step();
      $display("test_sequencer done");
   endtask

   // the tests need about 12600 clocks; nearly five times that is the limit
   initial begin
      repeat (60000) @(posedge core_clk);
      fails++;
      $display("ERROR %0t: watchdog expired", $time);
      results();
   end

   initial begin
      rst_n = 1'b0;
      fails = 0;
      checks_done = 0;
      repeat (12) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      i_spi_host_model.link_open();
      ones(RUN);
      i_spi_host_model.link_close();
      test_defaults();
      test_write();
      test_abort();
      test_run_reset();
      test_sequencer();
      results();
   end

endmodule
